// File: rtl/dag_gate.sv
// Debug authentication gate: samples enables and derives debug permissions
// Operation
// - Sync mode captures all enables only on sample clock rising edge.
// - Asynchronous mode passes enables through with no clock, deprecated.
// - Update latency is implementation defined; sampling may be frozen.
// - Software can poll a settle flag until prior changes took effect.
// - Every non-invasive enable used is paired with its invasive enable.
// - Invasive enable low blocks all invasive debug.
// - Both base enables low permit no debug at all.
// - Invasive from invasive enable; non-invasive from OR of both.
// - Secure invasive enable low blocks secure invasive debug.
// - Both secure enables low block all secure debug.
// - Secure non-invasive allowed when secure invasive enable high.
// - Secure invasive is AND of invasive and secure invasive enable.
// - Secure classes also need their non-secure counterpart permitted.
// - Hypervisor invasive enable low blocks hypervisor invasive debug.
// - Both hypervisor enables low block all hypervisor debug.
// - Hypervisor non-invasive allowed when hypervisor invasive enable high.
// - Hypervisor enables are supported together with the base enables.
// - Hypervisor classes AND with their non-hypervisor counterparts.
// - Realm enable gated by invasive; root by invasive, realm and secure invasive.
// - Root non-invasive permitted only with root invasive.
// - Realm non-invasive permitted only with realm invasive.
// - Root invasive is AND of invasive, realm, secure and root enables.
module dag_gate (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic auth_sample_clock,
  input wire logic auth_reset_n_a,
  input wire logic invasive_enable,
  input wire logic noninvasive_enable,
  input wire logic secure_invasive_enable,
  input wire logic secure_noninvasive_enable,
  input wire logic hyp_invasive_enable,
  input wire logic hyp_noninvasive_enable,
  input wire logic realm_invasive_enable,
  input wire logic root_invasive_enable,
  output logic [dag_pkg::DAG_PM_W-1:0] perm,
  output logic perm_ns_invasive,
  output logic perm_ns_noninvasive
);
  import dag_pkg::*;

  // ==========================================================
  // Register bus
  logic [2:0] ctrl_q;
  logic resample_q;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign addr_ok = (paddr == DAG_CTRL_OFS) | (paddr == DAG_RAW_OFS) |
                   (paddr == DAG_PERM_OFS) | (paddr == DAG_STAT_OFS);
  // Zero wait states keeps software polling cheap
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= DAG_CTRL_RST;
    end else if (wr_en && paddr == DAG_CTRL_OFS && pstrb[0]) begin
      ctrl_q <= {1'b0, pwdata[DAG_CTRL_FREEZE_BIT],
                 pwdata[DAG_CTRL_SYNC_BIT]};
    end
  end

  // One-shot resample request; set wins against the acknowledge below
  logic resample_ack;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resample_q <= 1'b0;
    end else if (wr_en && paddr == DAG_CTRL_OFS && pstrb[0] &&
                 pwdata[DAG_CTRL_RESAMPLE_BIT]) begin
      resample_q <= 1'b1;
    end else if (resample_ack) begin
      resample_q <= 1'b0;
    end
  end

  // ==========================================================
  // Enable capture
  logic [DAG_EN_W-1:0] raw_en;
  logic [DAG_EN_W-1:0] smp_q;
  logic [DAG_EN_W-1:0] eff_en;
  logic clk_prev_q;
  logic sample_edge;
  logic capture;
  logic sync_mode;

  assign raw_en = {root_invasive_enable, realm_invasive_enable,
                   hyp_noninvasive_enable, hyp_invasive_enable,
                   secure_noninvasive_enable, secure_invasive_enable,
                   noninvasive_enable, invasive_enable};

  assign sync_mode = ctrl_q[DAG_CTRL_SYNC_BIT];

  // Sample clock is another system clock, seen as a level on pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= auth_sample_clock;
    end
  end

  assign sample_edge = auth_sample_clock & ~clk_prev_q;
  assign capture = sample_edge &
                   (~ctrl_q[DAG_CTRL_FREEZE_BIT] | resample_q);
  assign resample_ack = capture;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_q <= '0;
    end else if (!auth_reset_n_a) begin
      smp_q <= '0;
    end else if (capture) begin
      smp_q <= raw_en;
    end
  end

  assign eff_en = sync_mode ? smp_q : raw_en;

  logic settled;
  assign settled = ~sync_mode | (smp_q == raw_en);

  // ==========================================================
  // Permission equations
  logic inv;
  logic ninv;
  logic realm_g;
  logic root_g;
  logic [DAG_PM_W-1:0] perm_d;

  always_comb begin
    perm_d = '0;
    inv = eff_en[DAG_EN_INV];
    ninv = eff_en[DAG_EN_INV] | eff_en[DAG_EN_NINV];
    realm_g = eff_en[DAG_EN_RLINV] & eff_en[DAG_EN_INV];
    root_g = eff_en[DAG_EN_RTINV] & realm_g;
    perm_d[DAG_PM_NS_INV] = inv;
    perm_d[DAG_PM_NS_NINV] = ninv;
    perm_d[DAG_PM_S_INV] = inv & eff_en[DAG_EN_SINV];
    perm_d[DAG_PM_S_NINV] = (eff_en[DAG_EN_SINV] | eff_en[DAG_EN_SNINV])
                            & ninv;
    perm_d[DAG_PM_H_INV] = inv & eff_en[DAG_EN_HINV];
    perm_d[DAG_PM_H_NINV] = (eff_en[DAG_EN_HINV] | eff_en[DAG_EN_HNINV])
                            & ninv;
    perm_d[DAG_PM_RL_INV] = realm_g;
    perm_d[DAG_PM_RL_NINV] = realm_g;
    perm_d[DAG_PM_RT_INV] = root_g & eff_en[DAG_EN_SINV];
    perm_d[DAG_PM_RT_NINV] = root_g & eff_en[DAG_EN_SINV];
  end

  // Registered so permissions never glitch mid-cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perm <= '0;
    end else begin
      perm <= perm_d;
    end
  end

  assign perm_ns_invasive = perm[DAG_PM_NS_INV];
  assign perm_ns_noninvasive = perm[DAG_PM_NS_NINV];

  // ==========================================================
  // Read data
  always_comb begin
    rdata_d = DAG_ZERO;
    case (paddr)
      DAG_CTRL_OFS: rdata_d[2:0] = {resample_q, ctrl_q[1:0]};
      DAG_RAW_OFS: rdata_d[DAG_EN_W-1:0] = smp_q;
      DAG_PERM_OFS: rdata_d[DAG_PM_W-1:0] = perm;
      DAG_STAT_OFS: rdata_d[0] = settled & ~resample_q;
      default: rdata_d = DAG_ZERO;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= DAG_ZERO;
    end else if (psel && !penable && !pwrite) begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rd_en ? rdata_q : DAG_ZERO;

endmodule // dag_gate

// File: rtl/dag_pkg.sv
// Package for the debug authentication gate: register map and constants
package dag_pkg;

  // APB register byte offsets
  localparam logic [11:0] DAG_CTRL_OFS = 12'h000;
  localparam logic [11:0] DAG_RAW_OFS = 12'h004;
  localparam logic [11:0] DAG_PERM_OFS = 12'h008;
  localparam logic [11:0] DAG_STAT_OFS = 12'h00C;

  // Control register fields
  localparam int DAG_CTRL_SYNC_BIT = 0;
  localparam int DAG_CTRL_FREEZE_BIT = 1;
  localparam int DAG_CTRL_RESAMPLE_BIT = 2;
  localparam logic [2:0] DAG_CTRL_RST = 3'h1;

  // Enable vector bit positions (raw and sampled)
  localparam int DAG_EN_INV = 0;
  localparam int DAG_EN_NINV = 1;
  localparam int DAG_EN_SINV = 2;
  localparam int DAG_EN_SNINV = 3;
  localparam int DAG_EN_HINV = 4;
  localparam int DAG_EN_HNINV = 5;
  localparam int DAG_EN_RLINV = 6;
  localparam int DAG_EN_RTINV = 7;
  localparam int DAG_EN_W = 8;

  // Permission vector bit positions
  localparam int DAG_PM_NS_INV = 0;
  localparam int DAG_PM_NS_NINV = 1;
  localparam int DAG_PM_S_INV = 2;
  localparam int DAG_PM_S_NINV = 3;
  localparam int DAG_PM_H_INV = 4;
  localparam int DAG_PM_H_NINV = 5;
  localparam int DAG_PM_RL_INV = 6;
  localparam int DAG_PM_RL_NINV = 7;
  localparam int DAG_PM_RT_INV = 8;
  localparam int DAG_PM_RT_NINV = 9;
  localparam int DAG_PM_W = 10;

  localparam logic [31:0] DAG_ZERO = 32'h0000_0000;

endpackage : dag_pkg

// File: verification/dag_auth_tx.sv
// Authentication transmitter model that drives the gate's enables
module dag_auth_tx (
  input wire logic clk,
  output logic sclk,
  output logic rst_n,
  output logic [7:0] en
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'b0;
    rst_n = 1'b0;
    en = 8'h00;
  end
  // Enables settle one cycle before any sample clock rise
  task automatic send(input logic [7:0] v, input logic pulse);
    @(posedge clk);
    en <= v;
    @(posedge clk);
    sclk <= pulse;
    @(posedge clk);
    sclk <= 1'b0;
  endtask
  task automatic link_rst(input logic v);
    @(posedge clk);
    rst_n <= v;
  endtask
endmodule // dag_auth_tx

// File: verification/dag_gate_properties.sv
// Checker for the permission outputs of the debug authentication gate
// ========
// Properties
module dag_gate_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [dag_pkg::DAG_PM_W-1:0] perm,
  input wire logic perm_ns_invasive,
  input wire logic perm_ns_noninvasive
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable; endsequence
  // Sampling mode is internal, so only mode-free relations are checked
  access_ready_a: assert property (setup_s ##1 access_s |-> pready)
    else $error("access without ready");
  err_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access");
  ns_order_a: assert property (perm[0] |-> perm[1])
    else $error("invasive without non-invasive");
  sec_inv_a: assert property (perm[2] |-> perm[0] && perm[3])
    else $error("secure invasive badly gated");
  sec_ninv_a: assert property (perm[3] |-> perm[1])
    else $error("secure non-invasive badly gated");
  hyp_inv_a: assert property (perm[4] |-> perm[0] && perm[5])
    else $error("hyp invasive badly gated");
  hyp_ninv_a: assert property (perm[5] |-> perm[1])
    else $error("hyp non-invasive badly gated");
  realm_pair_a: assert property (perm[7] == perm[6])
    else $error("realm pair differs");
  root_gate_a: assert property (perm[8] |-> perm[6] && perm[2])
    else $error("root invasive badly gated");
  root_pair_a: assert property (perm[9] == perm[8])
    else $error("root pair differs");
  ns_alias_a: assert property ({perm_ns_noninvasive, perm_ns_invasive}
    == perm[1:0]) else $error("alias outputs differ");
endmodule // dag_gate_properties

bind dag_gate dag_gate_properties i_props (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .perm, .perm_ns_invasive,
  .perm_ns_noninvasive);

// File: verification/dag_gate_tb.sv
// Testbench for the debug authentication gate
module dag_gate_tb;
  import dag_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, pni, pnn, sclk, arst_n, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = DAG_ZERO, prdata, r;
  logic [7:0] en;
  logic [DAG_PM_W-1:0] perm;
  int errors = 0, checks = 0;
  always #20 pclk = ~pclk;
  dag_auth_tx i_dag_auth_tx (.clk(pclk), .sclk, .rst_n(arst_n), .en);
  dag_gate i_dag_gate (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
    .auth_sample_clock(sclk), .auth_reset_n_a(arst_n),
    .invasive_enable(en[0]), .noninvasive_enable(en[1]),
    .secure_invasive_enable(en[2]), .secure_noninvasive_enable(en[3]),
    .hyp_invasive_enable(en[4]), .hyp_noninvasive_enable(en[5]),
    .realm_invasive_enable(en[6]), .root_invasive_enable(en[7]), .perm,
    .perm_ns_invasive(pni), .perm_ns_noninvasive(pnn));
  // ========
  // Helpers
  task automatic test_done;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      test_done();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, DAG_ZERO);
    chk(r, x);
  endtask
  function automatic logic [31:0] pm(input logic [7:0] v);
    logic i, n, q;
    i = v[0];
    n = v[0] | v[1];
    q = i & v[6];
    pm = 32'({{2{q & v[2] & v[7]}}, {2{q}}, (v[4] | v[5]) & n,
      i & v[4], (v[2] | v[3]) & n, i & v[2], n, i});
  endfunction
  // ========
  // Sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(DAG_CTRL_OFS, 32'(DAG_CTRL_RST));
    rd(DAG_PERM_OFS, DAG_ZERO);
    i_dag_auth_tx.link_rst(1'b1);
    for (int k = 0; k < 256; k++) begin
      i_dag_auth_tx.send(k[7:0], 1'b1);
      repeat (2) @(posedge pclk);
      chk(32'(perm), pm(k[7:0]));
      chk(32'({pnn, pni}), pm(k[7:0]) & 32'h0000_0003);
      rd(DAG_RAW_OFS, 32'(k[7:0]));
      rd(DAG_STAT_OFS, 32'h0000_0001);
      i_dag_auth_tx.send(~k[7:0], 1'b0);
      rd(DAG_PERM_OFS, pm(k[7:0]));
      rd(DAG_STAT_OFS, DAG_ZERO);
    end
    apb(1'b1, DAG_CTRL_OFS, 32'h0000_0003);
    i_dag_auth_tx.send(8'h5f, 1'b1);
    rd(DAG_PERM_OFS, pm(8'hff));
    apb(1'b1, DAG_CTRL_OFS, 32'h0000_0007);
    i_dag_auth_tx.send(8'h5f, 1'b1);
    rd(DAG_PERM_OFS, pm(8'h5f));
    i_dag_auth_tx.link_rst(1'b0);
    // Clear lands one edge after the low level, perm one edge later
    repeat (3) @(posedge pclk);
    chk(32'(perm), DAG_ZERO);
    rd(DAG_RAW_OFS, DAG_ZERO);
    i_dag_auth_tx.link_rst(1'b1);
    apb(1'b1, DAG_CTRL_OFS, DAG_ZERO);
    for (int k = 1; k < 256; k += 37) begin
      i_dag_auth_tx.send(k[7:0], 1'b0);
      repeat (2) @(posedge pclk);
      chk(32'(perm), pm(k[7:0]));
    end
    rd(12'h010, DAG_ZERO);
    chk(32'(e), 32'h0000_0001);
    test_done();
  end
endmodule // dag_gate_tb
